// [shared/idov_pkg.sv]
// package for the input-detect / over-voltage configuration register block
// assumes an AXI4-Lite master with 32-bit data and byte addressing
package idov_pkg;
    // ==========================================================
    // register indices; each word sits at four times its index, so all are word aligned
    localparam logic [7:0] IDX_PROTECT_CFG = 8'hD3;
    localparam logic [7:0] IDX_RISE_LEVEL = 8'hD4;
    localparam logic [7:0] IDX_OVP_LEVEL = 8'hD5;
    localparam int ADDR_W = 10;
    // ==========================================================
    // register byte addresses
    localparam logic [9:0] ADDR_PROTECT_CFG = {IDX_PROTECT_CFG, 2'h0};
    localparam logic [9:0] ADDR_RISE_LEVEL = {IDX_RISE_LEVEL, 2'h0};
    localparam logic [9:0] ADDR_OVP_LEVEL = {IDX_OVP_LEVEL, 2'h0};
    localparam int DATA_W = 32;
    // ==========================================================
    // field positions
    localparam int PROT_EN_BIT = 7;
    localparam int REG_SEL_BIT = 6;
    localparam int DET_EN_BIT = 5;
    localparam int LEVEL5_W = 5;
    localparam int LEVEL6_W = 6;
    // ==========================================================
    // reset values
    localparam logic [7:0] RST_PROTECT_CFG = 8'h20;
    localparam logic [7:0] RST_RISE_LEVEL = 8'h03;
    localparam logic [7:0] RST_OVP_LEVEL = 8'h3F;
    // ==========================================================
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : idov_pkg

// [logic/idov_field.sv]
// one byte-wide configuration register with a writable low field
// assumes write strobe and data come from the bus slave on the same clock
`timescale 1ns/1ps
`default_nettype none
module idov_field #(
    parameter int WIDTH = 8,
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // write side
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // stored value, upper bits zero
    output logic [7:0] value
);
    typedef struct packed {
        logic [WIDTH-1:0] field;
    } idov_field_st_t;

    idov_field_st_t st_ff;
    idov_field_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        // every written code is kept unchanged
        if (wr_en) begin
            nxt_st.field = wr_data[WIDTH-1:0];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_ff.field <= RESET_VAL[WIDTH-1:0];
        end else begin
            st_ff <= nxt_st;
        end
    end

    generate
        if (WIDTH < 8) begin : g_pad
            // bits above the field are not stored and read zero
            assign value = {{(8-WIDTH){1'b0}}, st_ff.field};
        end else begin : g_full
            assign value = st_ff.field;
        end
    endgenerate
endmodule : idov_field
`default_nettype wire

// [logic/idov_axi_rd.sv]
// read-data multiplexer for the configuration registers
// assumes register values are stable in the cycle the read address is taken
`timescale 1ns/1ps
`default_nettype none
module idov_axi_rd (
    // request
    input wire logic [9:0] addr,
    // register values
    input wire logic [7:0] protect_cfg,
    input wire logic [7:0] rise_level,
    input wire logic [7:0] ovp_level,
    // answer
    output logic [31:0] data,
    output logic [1:0] resp
);
    always_comb begin
        data = 32'h0000_0000;
        resp = idov_pkg::RESP_OKAY;
        case (addr)
            idov_pkg::ADDR_PROTECT_CFG: data = {24'h00_0000, protect_cfg};
            idov_pkg::ADDR_RISE_LEVEL: data = {24'h00_0000, rise_level};
            idov_pkg::ADDR_OVP_LEVEL: data = {24'h00_0000, ovp_level};
            default: resp = idov_pkg::RESP_SLVERR;
        endcase
    end
endmodule : idov_axi_rd
`default_nettype wire

// [logic/idov_regs.sv]
// input-detect and second over-voltage configuration registers, AXI4-Lite slave
// assumes a single clock; analog comparators read the level outputs directly
//
// Contract
// - bit 7 of the protection config enables input voltage protection, reset 0.
// - bit 6 of the protection config selects regulation in place of protection, reset 0.
// - bit 5 of the protection config enables the input voltage detector, reset 1.
// - bits 4:0 of the protection config hold the falling level, 2.7V plus 0.2V per code, reset 0.
// - bits 4:0 of the rise register hold the rising level, 2.8V plus 0.2V per code, reset 3.
// - bits 7:5 of the rise register and 7:6 of the over-voltage register ignore writes, read 0.
// - bits 5:0 of the over-voltage register hold the second over-voltage level code.
// - the rise register sits at 0xD4 and resets to 0x03.
// - the over-voltage register sits at 0xD5 and resets to 0x3F.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module idov_regs (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // axi write address
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi read address
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // analog configuration
    output logic input_protect_enable,
    output logic input_regulation_select,
    output logic input_detector_enable,
    output logic [4:0] detector_falling_level,
    output logic [4:0] detector_rising_level,
    output logic [5:0] second_overvoltage_level
);
    // ==========================================================
    // state
    typedef struct packed {
        logic aw_held;
        logic [9:0] aw_addr;
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
        logic w_held;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] protect_cfg;
    } idov_regs_st_t;

    idov_regs_st_t st_ff;
    idov_regs_st_t nxt_st;

    logic [7:0] rise_value;
    logic [7:0] ovp_value;
    logic [31:0] rd_data;
    logic [1:0] rd_resp;
    logic wr_fire;
    logic wr_lane_ok;
    logic wr_rise;
    logic wr_ovp;

    // ==========================================================
    // write decode
    // address and data may arrive in either order; the write commits once both are held and no write response is pending
    assign wr_fire = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
    // byte lane 0 carries the whole register; other lanes alone change nothing
    assign wr_lane_ok = wr_fire && st_ff.w_lane0;
    assign wr_rise = wr_lane_ok && (st_ff.aw_addr == idov_pkg::ADDR_RISE_LEVEL);
    assign wr_ovp = wr_lane_ok && (st_ff.aw_addr == idov_pkg::ADDR_OVP_LEVEL);

    // ==========================================================
    // level registers
    idov_field #(
        .WIDTH(idov_pkg::LEVEL5_W),
        .RESET_VAL(idov_pkg::RST_RISE_LEVEL)
    ) u_rise (
        .clock(clock),
        .reset(reset),
        .wr_en(wr_rise),
        .wr_data(st_ff.w_data),
        .value(rise_value)
    );

    idov_field #(
        .WIDTH(idov_pkg::LEVEL6_W),
        .RESET_VAL(idov_pkg::RST_OVP_LEVEL)
    ) u_ovp (
        .clock(clock),
        .reset(reset),
        .wr_en(wr_ovp),
        .wr_data(st_ff.w_data),
        .value(ovp_value)
    );

    idov_axi_rd u_rd (
        .addr(s_axi_araddr),
        .protect_cfg(st_ff.protect_cfg),
        .rise_level(rise_value),
        .ovp_level(ovp_value),
        .data(rd_data),
        .resp(rd_resp)
    );

    // ==========================================================
    // next state
    always_comb begin
        nxt_st = st_ff;
        // write address capture
        if (s_axi_awvalid && !st_ff.aw_held) begin
            nxt_st.aw_held = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        // write data capture
        if (s_axi_wvalid && !st_ff.w_held) begin
            nxt_st.w_held = 1'b1;
            nxt_st.w_data = s_axi_wdata[7:0];
            nxt_st.w_lane0 = s_axi_wstrb[0];
        end
        // commit and answer
        if (wr_fire) begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held = 1'b0;
            nxt_st.bvalid = 1'b1;
            case (st_ff.aw_addr)
                idov_pkg::ADDR_PROTECT_CFG,
                idov_pkg::ADDR_RISE_LEVEL,
                idov_pkg::ADDR_OVP_LEVEL: nxt_st.bresp = idov_pkg::RESP_OKAY;
                default: nxt_st.bresp = idov_pkg::RESP_SLVERR;
            endcase
            if (wr_lane_ok && (st_ff.aw_addr == idov_pkg::ADDR_PROTECT_CFG)) begin
                // all eight bits are implemented here
                nxt_st.protect_cfg = st_ff.w_data;
            end
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        // read: one cycle from the address handshake to rvalid
        if (s_axi_arvalid && !st_ff.rvalid) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = rd_data;
            nxt_st.rresp = rd_resp;
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        // readies are registered so the ports come straight from flops
        nxt_st.aw_rdy = !nxt_st.aw_held;
        nxt_st.w_rdy = !nxt_st.w_held;
        nxt_st.ar_rdy = !nxt_st.rvalid;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_ff.aw_held <= 1'b0;
            st_ff.aw_addr <= 10'h000;
            st_ff.aw_rdy <= 1'b1;
            st_ff.w_rdy <= 1'b1;
            st_ff.ar_rdy <= 1'b1;
            st_ff.w_held <= 1'b0;
            st_ff.w_data <= 8'h00;
            st_ff.w_lane0 <= 1'b0;
            st_ff.bvalid <= 1'b0;
            st_ff.bresp <= idov_pkg::RESP_OKAY;
            st_ff.rvalid <= 1'b0;
            st_ff.rdata <= 32'h0000_0000;
            st_ff.rresp <= idov_pkg::RESP_OKAY;
            st_ff.protect_cfg <= idov_pkg::RST_PROTECT_CFG;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // outputs, all from flip-flops
    // ready is a flop: it drops once a beat is held, so no second beat slips in
    assign s_axi_awready = st_ff.aw_rdy;
    assign s_axi_wready = st_ff.w_rdy;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = st_ff.ar_rdy;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;

    assign input_protect_enable = st_ff.protect_cfg[idov_pkg::PROT_EN_BIT];
    assign input_regulation_select = st_ff.protect_cfg[idov_pkg::REG_SEL_BIT];
    assign input_detector_enable = st_ff.protect_cfg[idov_pkg::DET_EN_BIT];
    assign detector_falling_level = st_ff.protect_cfg[idov_pkg::LEVEL5_W-1:0];
    assign detector_rising_level = rise_value[idov_pkg::LEVEL5_W-1:0];
    assign second_overvoltage_level = ovp_value[idov_pkg::LEVEL6_W-1:0];
endmodule : idov_regs
`default_nettype wire

// [tb/idov_regs_properties.sv]
// concurrent checks on the configuration register block
// assumes binding to idov_regs; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module idov_regs_chk (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    // configuration
    input wire logic input_protect_enable,
    input wire logic input_regulation_select,
    input wire logic input_detector_enable,
    input wire logic [4:0] detector_falling_level,
    input wire logic [4:0] detector_rising_level,
    input wire logic [5:0] second_overvoltage_level
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic [9:0] ra_ff;
    logic [18:0] cfg;
    assign cfg = {input_protect_enable, input_regulation_select, input_detector_enable,
        detector_falling_level, detector_rising_level, second_overvoltage_level};
    // ==========================================================
    // read address kept so each answer can be judged
    always_ff @(posedge clock or posedge reset) begin
        if (reset)
            ra_ff <= 10'h000;
        else if (s_axi_arvalid && s_axi_arready)
            ra_ff <= s_axi_araddr;
    end
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_ans(logic [9:0] a);
        s_axi_rvalid && ra_ff == a;
    endsequence
    a_write_resp: assert property (s_wr_take |-> ##[1:8] s_axi_bvalid) else $error("no write response");
    a_cfg_quiet: assert property (!$rose(s_axi_bvalid) |-> $stable(cfg)) else $error("config moved without write");
    a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    a_cfg_read: assert property (s_ans(idov_pkg::ADDR_PROTECT_CFG) |-> s_axi_rdata == {24'h0, cfg[18:11]}) else $error("bad cfg read");
    a_rise_read: assert property (s_ans(idov_pkg::ADDR_RISE_LEVEL) |-> s_axi_rdata == {27'h0, cfg[10:6]}) else $error("bad rise read");
    a_ovp_read: assert property (s_ans(idov_pkg::ADDR_OVP_LEVEL) |-> s_axi_rdata == {26'h0, cfg[5:0]}) else $error("bad ovp read");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
    a_reset_val: assert property ($past(reset) |-> cfg == {8'h20, 5'h03, 6'h3F}) else $error("bad reset value");
endmodule : idov_regs_chk
bind idov_regs idov_regs_chk i_idov_regs_chk (.clock, .reset, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .input_protect_enable, .input_regulation_select,
    .input_detector_enable, .detector_falling_level, .detector_rising_level,
    .second_overvoltage_level);
`default_nettype wire

// [tb/idov_regs_tb_top.sv]
// self-checking bench for the configuration register block
// assumes idov_regs and its checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module idov_regs_tb_top;
    // ==========================================================
    // signals
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [9:0] s_axi_awaddr = 10'h000;
    logic [9:0] s_axi_araddr = 10'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs_v;
    logic [31:0] s_axi_rdata, rd_v;
    logic input_protect_enable, input_regulation_select, input_detector_enable;
    logic [4:0] detector_falling_level, detector_rising_level;
    logic [5:0] second_overvoltage_level;
    logic [7:0] o_cfg;
    int n_errors = 0;
    int compares = 0;
    assign o_cfg = {input_protect_enable, input_regulation_select, input_detector_enable,
        detector_falling_level};
    always #10 clock = ~clock;
    idov_regs i_idov_regs (.clock, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .input_protect_enable,
        .input_regulation_select, .input_detector_enable, .detector_falling_level,
        .detector_rising_level, .second_overvoltage_level);
    // ==========================================================
    // bus and compare tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // no cycle count assumed: only the watchdog ends a hung wait
        do begin
            @(posedge clock);
            // each channel drops only at its own handshake edge
            s_axi_awvalid <= s_axi_awvalid & ~s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid & ~s_axi_wready;
        end while (!s_axi_bvalid);
        rs_v = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [9:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            s_axi_arvalid <= s_axi_arvalid & ~s_axi_arready;
        end while (!s_axi_rvalid);
        rd_v = s_axi_rdata;
        rs_v = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic wr_rd(input logic [9:0] a, input logic [7:0] d, input logic [7:0] e);
        // junk above the lane must never reach the register
        wr(a, {24'hA5C3E1, d}, 4'hF);
        chk("bresp", 32'h0, {30'h0, rs_v});
        rd(a);
        chk("rdata", {24'h0, e}, rd_v);
    endtask : wr_rd
    // ==========================================================
    // scenarios
    task automatic t_reset_vals;
        chk("cfg out", 32'h20, {24'h0, o_cfg});
        chk("rise out", 32'h03, {27'h0, detector_rising_level});
        chk("ovp out", 32'h3F, {26'h0, second_overvoltage_level});
        chk("readies", 32'h7, {29'h0, s_axi_awready, s_axi_wready, s_axi_arready});
        rd(idov_pkg::ADDR_PROTECT_CFG);
        chk("cfg rd", 32'h20, rd_v);
        rd(idov_pkg::ADDR_RISE_LEVEL);
        chk("rise rd", 32'h03, rd_v);
        rd(idov_pkg::ADDR_OVP_LEVEL);
        chk("ovp rd", 32'h3F, rd_v);
    endtask : t_reset_vals
    task automatic t_cfg_bits;
        logic [7:0] tb[6] = '{8'h80, 8'h40, 8'h20, 8'h1F, 8'h19, 8'h00};
        foreach (tb[i]) begin
            wr_rd(idov_pkg::ADDR_PROTECT_CFG, tb[i], tb[i]);
            chk("cfg out", {24'h0, tb[i]}, {24'h0, o_cfg});
        end
    endtask : t_cfg_bits
    task automatic t_unimpl;
        logic [23:0] tb[7] = '{24'hD4FF1F, 24'hD4E000, 24'hD5FF3F, 24'hD5C000,
            24'hD53E3E, 24'hD51818, 24'hD51919};
        foreach (tb[i]) begin
            wr_rd({tb[i][23:16], 2'h0}, tb[i][15:8], tb[i][7:0]);
            chk("level out", {24'h0, tb[i][7:0]}, tb[i][16] ? {26'h0, second_overvoltage_level}
                : {27'h0, detector_rising_level});
        end
    endtask : t_unimpl
    task automatic t_refuse;
        wr({8'hD6, 2'h0}, 32'hFF, 4'hF);
        chk("bresp", {30'h0, idov_pkg::RESP_SLVERR}, {30'h0, rs_v});
        rd({8'hD6, 2'h0});
        chk("rresp", {30'h0, idov_pkg::RESP_SLVERR}, {30'h0, rs_v});
        chk("rdata", 32'h0, rd_v);
        wr(idov_pkg::ADDR_RISE_LEVEL, 32'h05, 4'h0);
        chk("bresp", 32'h0, {30'h0, rs_v});
        rd(idov_pkg::ADDR_RISE_LEVEL);
        chk("rise kept", 32'h0, rd_v);
    endtask : t_refuse
    task automatic close_out;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    initial begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        t_reset_vals();
        t_cfg_bits();
        t_unimpl();
        t_refuse();
        @(posedge clock);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        t_reset_vals();
        close_out();
    end
    initial begin
        #100000;
        n_errors++;
        close_out();
    end
endmodule : idov_regs_tb_top
`default_nettype wire
